// [usbas_pkg.sv]
// usbas_pkg: constants for the usb address and status register block
//------------------------------------------------------------------------------
// Summary of operation
// - seven-bit writable device address in bits 6:0
// - address clears on power-on and usb reset
// - address register bit 7 reads zero
// - usb bus reset sets host reset flag
// - usb reset resets all usb logic
// - enabled function reset clears mask, keeps enable/shadow/connect
// - enabled function reset drives reset output pin
// - host reset flag read-only, cleared by vector write
// - resume detect sets flag, vector write clears
// - every host frame start sets flag
// - artificial frame start while unlocked sets flag
// - setup buffer overwrite sets flag
//------------------------------------------------------------------------------
package usbas_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_STATUS  = 16'hfffe;
  localparam logic [15:0] IDX_ADDRESS = 16'hffff;
  localparam logic [15:0] IDX_MASK    = 16'hfffd;
  localparam logic [15:0] IDX_CONTROL = 16'hfffc;
  localparam logic [15:0] IDX_VECTOR  = 16'hffb2;
  localparam logic [31:0] ADDR_STATUS  = {14'h0000, IDX_STATUS, 2'h0};
  localparam logic [31:0] ADDR_ADDRESS = {14'h0000, IDX_ADDRESS, 2'h0};
  localparam logic [31:0] ADDR_MASK    = {14'h0000, IDX_MASK, 2'h0};
  localparam logic [31:0] ADDR_CONTROL = {14'h0000, IDX_CONTROL, 2'h0};
  localparam logic [31:0] ADDR_VECTOR  = {14'h0000, IDX_VECTOR, 2'h0};
  // widths
  localparam int unsigned REG_W  = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned CNT_W  = 17;
  // status bit positions
  localparam int unsigned BIT_HOST_RESET = 7;
  localparam int unsigned BIT_SUSPEND    = 6;
  localparam int unsigned BIT_RESUME     = 5;
  localparam int unsigned BIT_FRAME      = 4;
  localparam int unsigned BIT_PSEUDO     = 3;
  localparam int unsigned BIT_SETUP      = 2;
  localparam int unsigned BIT_OVERWRITE  = 0;
  localparam logic [7:0]  STATUS_USED    = 8'hfd;
  // control bit positions
  localparam int unsigned BIT_FUNC_RESET_EN = 0;
  localparam int unsigned BIT_ROM_SHADOW    = 1;
  localparam int unsigned BIT_CONNECT       = 2;
  localparam logic [7:0]  CONTROL_USED      = 8'h07;
  // reset values
  localparam logic [7:0] RST_STATUS  = 8'h00;
  localparam logic [6:0] RST_ADDRESS = 7'h00;
  localparam logic [7:0] RST_MASK    = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  // timing: nominal frame period
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned FRAME_PERIOD_NS  = 1000000;
  localparam int unsigned FRAME_CYCLES_DEF = FRAME_PERIOD_NS / CLK_PERIOD_NS;
endpackage : usbas_pkg

// [usbas_frame_timer.sv]
// usbas_frame_timer: frame timer that makes artificial frame starts when unlocked
`timescale 1ns/10ps
`default_nettype none
module usbas_frame_timer #(
  parameter int unsigned FRAME_CYCLES = usbas_pkg::FRAME_CYCLES_DEF
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // control
  input  wire logic usb_clear,
  input  wire logic sof_detect,
  input  wire logic frame_locked,
  // event
  output logic      pseudo_sof
);
  import usbas_pkg::*;

  localparam logic [CNT_W-1:0] LAST_COUNT = CNT_W'(FRAME_CYCLES - 1);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic             pseudo_reg;
  logic             pseudo_next;

  //----------------------------------------------------------------------------
  // frame counter
  //----------------------------------------------------------------------------
  // a real frame start realigns the count so pseudo starts fall between them
  always_comb begin
    count_next  = count_reg + CNT_W'(1);
    pseudo_next = 1'b0;
    if (usb_clear) begin
      count_next = '0;
    end else if (sof_detect) begin
      count_next = '0;
    end else if (count_reg == LAST_COUNT) begin
      count_next  = '0;
      pseudo_next = !frame_locked;
    end
  end

  // register stage
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      count_reg  <= '0;
      pseudo_reg <= 1'b0;
    end else begin
      count_reg  <= count_next;
      pseudo_reg <= pseudo_next;
    end
  end

  assign pseudo_sof = pseudo_reg;

  AST_PSEUDO_ONLY_UNLOCKED : assert property (@(posedge clk_sys) disable iff (!reset_n)
    pseudo_sof |-> $past(!frame_locked) && $past(count_reg) == LAST_COUNT)
    else $error("artificial frame start while locked or off period");
endmodule : usbas_frame_timer
`default_nettype wire

// [usbas_regs_top.sv]
// usbas_regs_top: usb device address and status registers behind an apb slave
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module usbas_regs_top #(
  parameter int unsigned FRAME_CYCLES = usbas_pkg::FRAME_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          reset_n,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // usb logic events
  input  wire logic                          usb_bus_reset,
  input  wire logic                          suspend_detect,
  input  wire logic                          resume_detect,
  input  wire logic                          sof_detect,
  input  wire logic                          frame_locked,
  input  wire logic                          setup_done,
  input  wire logic                          setup_overwrite,
  // device outputs
  output logic      [usbas_pkg::ADDR_W-1:0]  device_address_field,
  output logic                               usb_logic_reset,
  output logic                               chip_logic_reset,
  output logic                               reset_output_pin,
  output logic                               rom_shadow_bit,
  output logic                               function_connect_bit,
  output logic                               irq
);
  import usbas_pkg::*;

  //----------------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------------
  logic [REG_W-1:0]  usb_status_flags_reg;
  logic [REG_W-1:0]  usb_status_flags_next;
  logic [ADDR_W-1:0] usb_device_address_reg;
  logic [ADDR_W-1:0] usb_device_address_next;
  logic [REG_W-1:0]  mask_reg;
  logic [REG_W-1:0]  mask_next;
  logic [REG_W-1:0]  control_reg;
  logic [REG_W-1:0]  control_next;
  logic              irq_reg;
  logic              irq_next;
  logic              usb_reset_reg;
  logic              chip_reset_reg;
  logic              chip_reset_next;
  logic [31:0]       prdata_reg;
  logic [31:0]       prdata_next;
  logic              pready_reg;
  logic              pready_next;
  logic              pslverr_reg;
  logic              pslverr_next;
  logic              pseudo_sof;
  logic [REG_W-1:0]  events;
  logic              apb_setup;
  logic              apb_write;
  logic              addr_hit;
  logic              vector_write;
  logic              func_reset_en;

  //----------------------------------------------------------------------------
  // bus decode
  //----------------------------------------------------------------------------
  // writes land only on the completing edge and only with lane 0 enabled
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready_reg && pwrite && !pslverr_reg && pstrb[0];
  assign addr_hit  = (paddr == ADDR_STATUS) || (paddr == ADDR_ADDRESS) ||
                     (paddr == ADDR_MASK) || (paddr == ADDR_CONTROL) ||
                     (paddr == ADDR_VECTOR);
  assign vector_write  = apb_write && (paddr == ADDR_VECTOR);
  assign func_reset_en = control_reg[BIT_FUNC_RESET_EN];

  //----------------------------------------------------------------------------
  // frame timer
  //----------------------------------------------------------------------------
  // the frame timer is part of the usb logic and restarts on a bus reset
  usbas_frame_timer #(
    .FRAME_CYCLES (FRAME_CYCLES)
  ) u_frame_timer (
    .clk_sys      (clk_sys),
    .reset_n      (reset_n),
    .usb_clear    (usb_bus_reset),
    .sof_detect   (sof_detect),
    .frame_locked (frame_locked),
    .pseudo_sof   (pseudo_sof)
  );

  //----------------------------------------------------------------------------
  // status flags
  //----------------------------------------------------------------------------
  // gather hardware events into status layout; bit 1 stays zero
  always_comb begin
    events                 = '0;
    events[BIT_HOST_RESET] = usb_bus_reset;
    events[BIT_SUSPEND]    = suspend_detect;
    events[BIT_RESUME]     = resume_detect;
    events[BIT_FRAME]      = sof_detect;
    events[BIT_PSEUDO]     = pseudo_sof;
    events[BIT_SETUP]      = setup_done;
    events[BIT_OVERWRITE]  = setup_overwrite;
  end

  // a vector write clears every flag; an event in the same cycle still wins
  always_comb begin
    usb_status_flags_next = usb_status_flags_reg;
    if (vector_write) begin
      usb_status_flags_next = '0;
    end
    usb_status_flags_next = (usb_status_flags_next | events) & STATUS_USED;
  end

  //----------------------------------------------------------------------------
  // device address, mask and control
  //----------------------------------------------------------------------------
  // bus reset beats a firmware write in the same cycle to the address, and to the mask when function reset is enabled
  always_comb begin
    usb_device_address_next = usb_device_address_reg;
    mask_next               = mask_reg;
    control_next            = control_reg;
    if (apb_write && (paddr == ADDR_ADDRESS)) begin
      usb_device_address_next = pwdata[ADDR_W-1:0];
    end
    if (apb_write && (paddr == ADDR_MASK)) begin
      mask_next = pwdata[REG_W-1:0] & STATUS_USED;
    end
    if (apb_write && (paddr == ADDR_CONTROL)) begin
      control_next = pwdata[REG_W-1:0] & CONTROL_USED;
    end
    if (usb_bus_reset) begin
      usb_device_address_next = RST_ADDRESS;
    end
    // the function reset enable itself survives so the reset can persist
    if (usb_bus_reset && func_reset_en) begin
      mask_next = RST_MASK;
    end
  end

  // reset outputs follow the bus reset level for as long as it lasts
  always_comb begin
    chip_reset_next = usb_bus_reset && func_reset_en;
  end

  // computed from next values so irq rises with the flag, not a cycle later
  always_comb begin
    irq_next = |(usb_status_flags_next & mask_next);
  end

  //----------------------------------------------------------------------------
  // apb answer
  //----------------------------------------------------------------------------
  // read data is captured in the setup cycle; the slave always answers in one
  always_comb begin
    prdata_next  = '0;
    pready_next  = apb_setup;
    pslverr_next = apb_setup && !addr_hit;
    if (apb_setup && !pwrite) begin
      case (paddr)
        ADDR_STATUS:  prdata_next[REG_W-1:0] = usb_status_flags_reg;
        ADDR_ADDRESS: prdata_next[ADDR_W-1:0] = usb_device_address_reg;
        ADDR_MASK:    prdata_next[REG_W-1:0] = mask_reg;
        ADDR_CONTROL: prdata_next[REG_W-1:0] = control_reg;
        default:      prdata_next = '0;
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // registers
  //----------------------------------------------------------------------------
  // power-on reset puts everything at its documented default
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      usb_status_flags_reg   <= RST_STATUS;
      usb_device_address_reg <= RST_ADDRESS;
      mask_reg               <= RST_MASK;
      control_reg            <= RST_CONTROL;
      irq_reg                <= 1'b0;
      usb_reset_reg          <= 1'b0;
      chip_reset_reg         <= 1'b0;
      prdata_reg             <= '0;
      pready_reg             <= 1'b0;
      pslverr_reg            <= 1'b0;
    end else begin
      usb_status_flags_reg   <= usb_status_flags_next;
      usb_device_address_reg <= usb_device_address_next;
      mask_reg               <= mask_next;
      control_reg            <= control_next;
      irq_reg                <= irq_next;
      usb_reset_reg          <= usb_bus_reset;
      chip_reset_reg         <= chip_reset_next;
      prdata_reg             <= prdata_next;
      pready_reg             <= pready_next;
      pslverr_reg            <= pslverr_next;
    end
  end

  //----------------------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------------------
  assign prdata               = prdata_reg;
  assign pready               = pready_reg;
  assign pslverr              = pslverr_reg;
  assign device_address_field = usb_device_address_reg;
  assign usb_logic_reset      = usb_reset_reg;
  assign chip_logic_reset     = chip_reset_reg;
  assign reset_output_pin     = chip_reset_reg;
  assign rom_shadow_bit       = control_reg[BIT_ROM_SHADOW];
  assign function_connect_bit = control_reg[BIT_CONNECT];
  assign irq                  = irq_reg;

  //----------------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------------
  AST_ADDR_WRITE : assert property (@(posedge clk_sys) disable iff (!reset_n)
    apb_write && (paddr == ADDR_ADDRESS) && !usb_bus_reset
    |=> device_address_field == $past(pwdata[ADDR_W-1:0]))
    else $error("device address did not take the written value");

  AST_ADDR_CLEAR : assert property (@(posedge clk_sys) disable iff (!reset_n)
    usb_bus_reset |=> device_address_field == RST_ADDRESS)
    else $error("device address not cleared by usb reset");

  AST_ADDR_BIT7 : assert property (@(posedge clk_sys) disable iff (!reset_n)
    apb_setup && !pwrite && (paddr == ADDR_ADDRESS)
    |=> pready && prdata[31:ADDR_W] == '0 && prdata[ADDR_W-1:0] == $past(usb_device_address_reg))
    else $error("address read returned wrong data or set bit 7");

  AST_HOST_RESET_SET : assert property (@(posedge clk_sys) disable iff (!reset_n)
    usb_bus_reset |=> usb_status_flags_reg[BIT_HOST_RESET])
    else $error("host reset flag not set");

  AST_USB_LOGIC_RESET : assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(usb_bus_reset) |=> usb_logic_reset ##1 (usb_logic_reset == $past(usb_bus_reset)))
    else $error("usb logic reset does not follow bus reset");

  AST_CHIP_RESET_KEEP : assert property (@(posedge clk_sys) disable iff (!reset_n)
    usb_bus_reset && func_reset_en && !apb_write
    |=> chip_logic_reset && mask_reg == RST_MASK && $stable(rom_shadow_bit) && $stable(function_connect_bit))
    else $error("function reset wrong or shadow/connect disturbed");

  AST_RESET_PIN : assert property (@(posedge clk_sys) disable iff (!reset_n)
    ##1 reset_output_pin == ($past(usb_bus_reset) && $past(func_reset_en)))
    else $error("reset output pin does not match reset and enable");

  AST_VECTOR_CLEAR : assert property (@(posedge clk_sys) disable iff (!reset_n)
    vector_write |=> usb_status_flags_reg == ($past(events) & STATUS_USED))
    else $error("vector write did not clear flags or lost an event");

  AST_SUSPEND_RESUME : assert property (@(posedge clk_sys) disable iff (!reset_n)
    suspend_detect || resume_detect
    |=> (usb_status_flags_reg[BIT_SUSPEND] == $past(suspend_detect) || $past(usb_status_flags_reg[BIT_SUSPEND]))
    && (usb_status_flags_reg[BIT_RESUME] || !$past(resume_detect)))
    else $error("suspend or resume flag not raised");

  AST_FRAME_FLAGS : assert property (@(posedge clk_sys) disable iff (!reset_n)
    sof_detect || setup_overwrite
    |=> (usb_status_flags_reg[BIT_FRAME] || !$past(sof_detect))
    && (usb_status_flags_reg[BIT_OVERWRITE] || !$past(setup_overwrite)))
    else $error("frame start or overwrite flag not raised");

  AST_PSEUDO_FLAG : assert property (@(posedge clk_sys) disable iff (!reset_n)
    pseudo_sof |=> usb_status_flags_reg[BIT_PSEUDO] && irq == |(usb_status_flags_reg & mask_reg))
    else $error("pseudo frame flag or irq wrong");

  AST_FLAGS_STICKY : assert property (@(posedge clk_sys) disable iff (!reset_n)
    !vector_write
    |=> (usb_status_flags_reg & $past(usb_status_flags_reg)) == $past(usb_status_flags_reg))
    else $error("status flag dropped without a vector write");

  AST_STATUS_WRITE_IGNORED : assert property (@(posedge clk_sys) disable iff (!reset_n)
    apb_write && (paddr == ADDR_STATUS)
    |=> usb_status_flags_reg == (($past(usb_status_flags_reg) | $past(events)) & STATUS_USED))
    else $error("write to read-only status changed flags");

  AST_UNMAPPED_REFUSED : assert property (@(posedge clk_sys) disable iff (!reset_n)
    apb_setup && !addr_hit |=> pready && pslverr && prdata == '0)
    else $error("unmapped access not refused");

  AST_ADDR_HOLD : assert property (@(posedge clk_sys) disable iff (!reset_n)
    !usb_bus_reset && !(apb_write && (paddr == ADDR_ADDRESS))
    |=> $stable(device_address_field))
    else $error("device address changed without write or usb reset");

  AST_NO_FUNC_RESET : assert property (@(posedge clk_sys) disable iff (!reset_n)
    !func_reset_en |=> !chip_logic_reset && !reset_output_pin)
    else $error("function reset raised while disabled");

  AST_MASK_KEPT : assert property (@(posedge clk_sys) disable iff (!reset_n)
    usb_bus_reset && !func_reset_en && !apb_write |=> mask_reg == $past(mask_reg))
    else $error("mask cleared by usb reset while function reset disabled");

  AST_IRQ_LEVEL : assert property (@(posedge clk_sys) disable iff (!reset_n)
    irq == |(usb_status_flags_reg & mask_reg))
    else $error("interrupt does not match unmasked flags");
endmodule : usbas_regs_top
`default_nettype wire

// [usbas_usb_model.sv]
// usbas_usb_model: usb side of the block, turns bench requests into event pulses
`timescale 1ns/10ps
`default_nettype none
module usbas_usb_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // requests in status bit layout
  input  wire logic [7:0] ev_req,
  // usb logic events
  output logic            usb_bus_reset,
  output logic            suspend_detect,
  output logic            resume_detect,
  output logic            sof_detect,
  output logic            setup_done,
  output logic            setup_overwrite
);
  logic [7:0] ev_reg;
  // registered so each event leaves right after an edge; a held request gives a level
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ev_reg <= 8'h00;
    end else begin
      ev_reg <= ev_req;
    end
  end
  // host bus reset is a level for as long as the bench holds it
  assign usb_bus_reset   = ev_reg[7];
  assign suspend_detect  = ev_reg[6];
  assign resume_detect   = ev_reg[5];
  assign sof_detect      = ev_reg[4];
  assign setup_done      = ev_reg[2];
  assign setup_overwrite = ev_reg[0];
endmodule : usbas_usb_model
`default_nettype wire

// [tb_top.sv]
// tb_top: self-checking bench for the usb address and status registers
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import usbas_pkg::*;
  localparam int FC = 20; // short frame so pseudo starts come quickly
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, frame_locked = 1'b1;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'h0;
  logic [7:0]  ev_req = 8'h00;
  logic [6:0]  device_address_field;
  logic        pready, pslverr, err, irq, usb_logic_reset, chip_logic_reset, reset_output_pin;
  logic        rom_shadow_bit, function_connect_bit, usb_bus_reset, suspend_detect, resume_detect;
  logic        sof_detect, setup_done, setup_overwrite;
  int          fail_count = 0, n_tests = 0, cycles = 0, seed, i, k, b;
  logic [31:0] d;
  int          ev_bits[5] = '{6, 5, 4, 2, 0};

  always #5 clk_sys = ~clk_sys;

  usbas_regs_top #(.FRAME_CYCLES(FC)) uut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .usb_bus_reset(usb_bus_reset),
    .suspend_detect(suspend_detect), .resume_detect(resume_detect), .sof_detect(sof_detect),
    .frame_locked(frame_locked), .setup_done(setup_done), .setup_overwrite(setup_overwrite),
    .device_address_field(device_address_field), .usb_logic_reset(usb_logic_reset),
    .chip_logic_reset(chip_logic_reset), .reset_output_pin(reset_output_pin),
    .rom_shadow_bit(rom_shadow_bit), .function_connect_bit(function_connect_bit), .irq(irq));

  usbas_usb_model usb (.clk_sys(clk_sys), .reset_n(reset_n), .ev_req(ev_req),
    .usb_bus_reset(usb_bus_reset), .suspend_detect(suspend_detect), .resume_detect(resume_detect),
    .sof_detect(sof_detect), .setup_done(setup_done), .setup_overwrite(setup_overwrite));

  //----------------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------------
  task automatic report_and_stop;
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // address register keeps seven bits, top bit always reads zero
  function automatic logic [31:0] addr_exp(input logic [31:0] v);
    return {25'h0, v[6:0]};
  endfunction : addr_exp

  // one apb transfer; request held until pready is seen, no latency assumed
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= v;
    pstrb   <= 4'hf;
    @(posedge clk_sys);
    penable <= 1'b1;
    // answer and data are taken at the rising edge that sees pready; only the hang guard ends the wait
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  // one-cycle event request, then let the flag settle
  task automatic fire(input logic [7:0] m);
    @(posedge clk_sys);
    ev_req <= m;
    @(posedge clk_sys);
    ev_req <= 8'h00;
    repeat (3) @(posedge clk_sys);
  endtask : fire

  // host bus reset held four cycles, outputs looked at while it stands and after
  task automatic busrst(input logic en);
    @(posedge clk_sys);
    ev_req <= 8'h80;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check({31'h0, usb_logic_reset}, 32'h1);
    check({31'h0, chip_logic_reset}, {31'h0, en});
    check({31'h0, reset_output_pin}, {31'h0, en});
    check({25'h0, device_address_field}, 32'h0);
    @(posedge clk_sys);
    ev_req <= 8'h00;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check({31'h0, usb_logic_reset}, 32'h0);
    check({31'h0, reset_output_pin}, 32'h0);
  endtask : busrst

  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  //----------------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------------
  initial begin
    seed = 1903;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rdchk(ADDR_STATUS, 32'h0);
    rdchk(ADDR_ADDRESS, 32'h0);
    // address writes, all-ones corner first
    for (i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hff : $random(seed);
      wr(ADDR_ADDRESS, d);
      rdchk(ADDR_ADDRESS, addr_exp(d));
      check({25'h0, device_address_field}, addr_exp(d));
    end
    // suspend, resume, frame, setup and overwrite each set their flag and interrupt, vector write clears both
    for (k = 0; k < 5; k++) begin
      b = ev_bits[k];
      wr(ADDR_MASK, 32'h1 << b);
      fire(8'h01 << b);
      check({31'h0, irq}, 32'h1);
      rdchk(ADDR_STATUS, 32'h1 << b);
      wr(ADDR_VECTOR, $random(seed));
      rdchk(ADDR_STATUS, 32'h0);
      check({31'h0, irq}, 32'h0);
    end
    // status is read-only; unmapped address is refused
    fire(8'h50);
    wr(ADDR_STATUS, 32'h0);
    rdchk(ADDR_STATUS, 32'h50);
    apb(1'b0, 32'h100, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // bus reset without and with the function reset enable
    for (i = 0; i < 2; i++) begin
      wr(ADDR_VECTOR, 32'h0);
      wr(ADDR_ADDRESS, $random(seed) | 32'h1);
      wr(ADDR_CONTROL, 32'h6 | i);
      wr(ADDR_MASK, 32'h80);
      busrst(i[0]);
      rdchk(ADDR_STATUS, 32'h80);
      check({31'h0, irq}, {31'h0, ~i[0]});
      rdchk(ADDR_MASK, i ? 32'h0 : 32'h80);
      rdchk(ADDR_CONTROL, 32'h6 | i);
      check({30'h0, function_connect_bit, rom_shadow_bit}, 32'h3);
      rdchk(ADDR_ADDRESS, 32'h0);
    end
    // artificial frame starts only while unlocked and without host frames
    frame_locked <= 1'b0;
    wr(ADDR_VECTOR, 32'h0);
    repeat (2 * FC + 5) @(posedge clk_sys);
    rdchk(ADDR_STATUS, 32'h08);
    frame_locked <= 1'b1;
    wr(ADDR_VECTOR, 32'h0);
    repeat (2 * FC + 5) @(posedge clk_sys);
    rdchk(ADDR_STATUS, 32'h0);
    frame_locked <= 1'b0;
    fire(8'h10);
    wr(ADDR_VECTOR, 32'h0);
    for (i = 0; i < 5; i++) begin
      fire(8'h10);
      repeat (6) @(posedge clk_sys);
    end
    rdchk(ADDR_STATUS, 32'h10);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
